// >>> logic/ocp_consts.svh
// offsets, field positions, key values and timing figures of the page programmer
`ifndef OCP_CONSTS_SVH
`define OCP_CONSTS_SVH
`define OCP_A_PAGE1_STAT 8'h00
`define OCP_A_PAGE2_STAT 8'h01
`define OCP_A_SEC_BLK 8'h02
`define OCP_A_DED_BLK 8'h03
`define OCP_A_KEY1A 8'h10
`define OCP_A_KEY1B 8'h11
`define OCP_A_KEY1C 8'h12
`define OCP_A_KEY1D 8'h13
`define OCP_A_KEY2A 8'h14
`define OCP_A_KEY2B 8'h15
`define OCP_A_KEY2C 8'h16
`define OCP_A_KEY2D 8'h17
`define OCP_A_BURN_STAT 8'h20
`define OCP_A_BURN_CTRL 8'h21
`define OCP_A_CTRL1 8'h22
`define OCP_K1A 8'h02
`define OCP_K1B 8'hB7
`define OCP_K1C 8'h78
`define OCP_K1D 8'hBC
`define OCP_K2A 8'h7E
`define OCP_K2B 8'h12
`define OCP_K2C 8'h08
`define OCP_K2D 8'h6F
`define OCP_GO_PAGE1 8'h01
`define OCP_GO_PAGE2 8'h03
// page status bits
`define OCP_PS_OK 0
`define OCP_PS_LOADED 1
`define OCP_PS_WRN 2
`define OCP_PS_LERR 3
`define OCP_PS_TRY 4
`define OCP_PS_FMT 5
`define OCP_PS_OV 6
`define OCP_PS_UV 7
// burn status bits
`define OCP_BS_DONE 0
`define OCP_BS_UNLOCK 1
`define OCP_BS_UV 2
`define OCP_BS_OV 3
`define OCP_BS_SUV 4
`define OCP_BS_SOV 5
`define OCP_BS_PAGE 6
`define OCP_BS_HOT 7
`define OCP_CTRL1_SOFTRST 0
`define OCP_BURN_MS 100
`define OCP_CLK_MHZ 100
`define OCP_BURN_CYC (`OCP_BURN_MS * 1000 * `OCP_CLK_MHZ)
`define OCP_STAB_CYC 16
`define OCP_BLOCKS 8
`define OCP_ZERO8 8'h00
`endif

// >>> logic/ocp_pkg.sv
// types shared by the page programmer
`default_nettype none
package ocp_pkg;
  typedef enum logic [2:0] {OCP_IDLE, OCP_LOAD, OCP_STAB, OCP_BURN} ocp_state_e;
  typedef enum logic [2:0] {KS_NONE, KS_1A, KS_1B, KS_1C, KS_1D, KS_2A, KS_2B, KS_2C} ocp_key_e;
endpackage
`default_nettype wire

// >>> logic/ocp_page_mem.sv
// nonvolatile page array model: two pages of blocks with per-block error tags
`timescale 1ns/1ps
`default_nettype none
module ocp_page_mem
  import ocp_pkg::*;
#(
  parameter int BLOCKS = 8,
  parameter int AW = 4
) (
  input wire logic clk,
  input wire logic [AW-1:0] rdAddr,
  output logic [1:0] rdErr,
  input wire logic wrEn,
  input wire logic wrPage
);
  // per block: bit0 single error, bit1 double error; burning clears a page's marks
  // powers up clean; only the clocked process below writes it
  logic [1:0] errMem [0:2*BLOCKS-1] = '{default: 2'h0};
  logic [1:0] rdErrR;
  always_ff @(posedge clk) begin
    rdErrR <= errMem[rdAddr];
    if (wrEn) begin
      for (int i = 0; i < BLOCKS; i++) begin
        errMem[{wrPage, i[AW-2:0]}] <= 2'h0;
      end
    end
  end
  assign rdErr = rdErrR;
endmodule // ocp_page_mem
`default_nettype wire

// >>> logic/ocp_programmer.sv
// customer page programmer: load report, key unlock, burn sequencing
//
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "ocp_consts.svh"
module ocp_programmer
  import ocp_pkg::*;
#(
  parameter int BURN_CYC = `OCP_BURN_CYC,
  parameter int STAB_CYC = `OCP_STAB_CYC,
  parameter int BLOCKS = `OCP_BLOCKS
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrStb,
  input wire logic rdStb,
  output logic [7:0] rdData,
  input wire logic burnUnderVolt,
  input wire logic burnOverVolt,
  input wire logic dieTooHot,
  output logic burnBusy,
  output logic softResetPulse
);
  localparam int AW = $clog2(2*BLOCKS);
  localparam int CW = $clog2(BURN_CYC + 1);

  typedef struct packed {
    ocp_state_e st;
    ocp_key_e key;
    logic unlocked;
    logic [7:0] page1Stat;
    logic [7:0] page2Stat;
    logic [7:0] burnStat;
    logic [7:0] secBlk;
    logic [7:0] dedBlk;
    logic [7:0] rdData;
    logic [AW-1:0] loadIdx;
    logic loadPend;
    logic burnPage;
    logic [CW-1:0] cnt;
    logic burnUv;
    logic burnOv;
    logic softRst;
    logic busy;
  } ocp_state_s;

  ocp_state_s s_reg;
  ocp_state_s s_next;
  logic [1:0] blkErr;
  logic memWr;

  ocp_page_mem #(.BLOCKS(BLOCKS), .AW(AW)) u_mem (
    .clk(clk),
    .rdAddr(s_reg.loadIdx),
    .rdErr(blkErr),
    .wrEn(memWr),
    .wrPage(s_reg.burnPage)
  );

  function automatic logic [7:0] keyWant(input ocp_key_e k);
    case (k)
      KS_NONE: keyWant = `OCP_K1A;
      KS_1A: keyWant = `OCP_K1B;
      KS_1B: keyWant = `OCP_K1C;
      KS_1C: keyWant = `OCP_K1D;
      KS_1D: keyWant = `OCP_K2A;
      KS_2A: keyWant = `OCP_K2B;
      KS_2B: keyWant = `OCP_K2C;
      KS_2C: keyWant = `OCP_K2D;
      default: keyWant = `OCP_ZERO8;
    endcase
  endfunction

  function automatic logic [7:0] keyAddr(input ocp_key_e k);
    case (k)
      KS_NONE: keyAddr = `OCP_A_KEY1A;
      KS_1A: keyAddr = `OCP_A_KEY1B;
      KS_1B: keyAddr = `OCP_A_KEY1C;
      KS_1C: keyAddr = `OCP_A_KEY1D;
      KS_1D: keyAddr = `OCP_A_KEY2A;
      KS_2A: keyAddr = `OCP_A_KEY2B;
      KS_2B: keyAddr = `OCP_A_KEY2C;
      KS_2C: keyAddr = `OCP_A_KEY2D;
      default: keyAddr = `OCP_ZERO8;
    endcase
  endfunction

  logic pageAvail;
  logic goValid;

  always_comb begin
    s_next = s_reg;
    s_next.rdData = `OCP_ZERO8;
    s_next.softRst = 1'b0;
    memWr = 1'b0;
    pageAvail = 1'b0;
    goValid = 1'b0;

    // register reads; a read between key bytes voids the sequence
    if (rdStb) begin
      case (addr)
        `OCP_A_PAGE1_STAT: s_next.rdData = s_reg.page1Stat;
        `OCP_A_PAGE2_STAT: s_next.rdData = s_reg.page2Stat;
        `OCP_A_SEC_BLK: s_next.rdData = s_reg.secBlk;
        `OCP_A_DED_BLK: s_next.rdData = s_reg.dedBlk;
        `OCP_A_BURN_STAT: s_next.rdData = s_reg.burnStat;
        default: s_next.rdData = `OCP_ZERO8;
      endcase
      if (s_reg.key != KS_NONE) begin
        s_next.key = KS_NONE;
      end
    end

    // writes; trigger accepted only straight after unlock
    if (wrStb && s_reg.st == OCP_IDLE) begin
      s_next.unlocked = 1'b0;
      s_next.burnStat[`OCP_BS_UNLOCK] = 1'b0;
      if (addr == keyAddr(s_reg.key) && wrData == keyWant(s_reg.key)) begin
        if (s_reg.key == KS_2C) begin
          s_next.key = KS_NONE;
          s_next.unlocked = 1'b1;
          s_next.burnStat[`OCP_BS_UNLOCK] = 1'b1;
        end else begin
          s_next.key = ocp_key_e'(s_reg.key + 3'h1);
        end
      end else begin
        s_next.key = KS_NONE;
        if (addr == `OCP_A_BURN_CTRL && s_reg.unlocked &&
            (wrData == `OCP_GO_PAGE1 || wrData == `OCP_GO_PAGE2)) begin
          goValid = 1'b1;
        end
        if (addr == `OCP_A_CTRL1 && wrData[`OCP_CTRL1_SOFTRST]) begin
          s_next.softRst = 1'b1;
          s_next.st = OCP_LOAD;
          s_next.loadIdx = '0;
          s_next.loadPend = 1'b1;
          s_next.secBlk = `OCP_ZERO8;
          s_next.dedBlk = `OCP_ZERO8;
          s_next.page1Stat[`OCP_PS_LOADED] = 1'b0;
          s_next.page1Stat[`OCP_PS_WRN] = 1'b0;
          s_next.page1Stat[`OCP_PS_LERR] = 1'b0;
          s_next.page2Stat[`OCP_PS_LOADED] = 1'b0;
          s_next.page2Stat[`OCP_PS_WRN] = 1'b0;
          s_next.page2Stat[`OCP_PS_LERR] = 1'b0;
        end
      end
    end

    if (goValid) begin
      s_next.burnStat = `OCP_ZERO8;
      s_next.burnPage = wrData == `OCP_GO_PAGE2;
      if (wrData == `OCP_GO_PAGE2) begin
        pageAvail = !s_reg.page2Stat[`OCP_PS_TRY] && !s_reg.page2Stat[`OCP_PS_FMT];
      end else begin
        pageAvail = !s_reg.page1Stat[`OCP_PS_TRY] && !s_reg.page1Stat[`OCP_PS_FMT];
      end
      if (!pageAvail) begin
        s_next.burnStat[`OCP_BS_PAGE] = 1'b1;
      end else if (dieTooHot) begin
        s_next.burnStat[`OCP_BS_HOT] = 1'b1;
      end else begin
        s_next.st = OCP_STAB;
        s_next.cnt = '0;
        s_next.burnUv = 1'b0;
        s_next.burnOv = 1'b0;
      end
    end

    case (s_reg.st)
      OCP_IDLE: begin
      end
      OCP_LOAD: begin
        // memory read data lags the index by one cycle
        if (s_reg.loadPend) begin
          s_next.loadPend = 1'b0;
        end else begin
          if (blkErr[1]) begin
            s_next.dedBlk = 8'(s_reg.loadIdx);
            if (s_reg.loadIdx[AW-1]) s_next.page2Stat[`OCP_PS_LERR] = 1'b1;
            else s_next.page1Stat[`OCP_PS_LERR] = 1'b1;
          end else if (blkErr[0]) begin
            s_next.secBlk = 8'(s_reg.loadIdx);
            if (s_reg.loadIdx[AW-1]) s_next.page2Stat[`OCP_PS_WRN] = 1'b1;
            else s_next.page1Stat[`OCP_PS_WRN] = 1'b1;
          end
          if (s_reg.loadIdx == AW'(2*BLOCKS-1)) begin
            s_next.st = OCP_IDLE;
            // newest valid page is the load source
            if (s_reg.page2Stat[`OCP_PS_OK]) s_next.page2Stat[`OCP_PS_LOADED] = 1'b1;
            else if (s_reg.page1Stat[`OCP_PS_OK]) s_next.page1Stat[`OCP_PS_LOADED] = 1'b1;
          end else begin
            s_next.loadIdx = s_reg.loadIdx + AW'(1);
            s_next.loadPend = 1'b1;
          end
        end
      end
      OCP_STAB: begin
        s_next.cnt = s_reg.cnt + CW'(1);
        if (burnUnderVolt || burnOverVolt) begin
          // attempt flag untouched: page stays available
          s_next.burnStat[`OCP_BS_SUV] = burnUnderVolt;
          s_next.burnStat[`OCP_BS_SOV] = burnOverVolt;
          s_next.st = OCP_IDLE;
        end else if (s_reg.cnt == CW'(STAB_CYC - 1)) begin
          s_next.cnt = '0;
          s_next.st = OCP_BURN;
          if (s_reg.burnPage) s_next.page2Stat[`OCP_PS_TRY] = 1'b1;
          else s_next.page1Stat[`OCP_PS_TRY] = 1'b1;
        end
      end
      OCP_BURN: begin
        s_next.cnt = s_reg.cnt + CW'(1);
        if (burnUnderVolt) begin
          s_next.burnUv = 1'b1;
          s_next.burnStat[`OCP_BS_UV] = 1'b1;
        end
        if (burnOverVolt) begin
          s_next.burnOv = 1'b1;
          s_next.burnStat[`OCP_BS_OV] = 1'b1;
        end
        if (s_reg.cnt == CW'(BURN_CYC - 1)) begin
          s_next.st = OCP_IDLE;
          s_next.burnStat[`OCP_BS_DONE] = 1'b1;
          memWr = 1'b1;
          if (s_reg.burnPage) begin
            // next-state flags so an excursion in the last cycle still counts
            s_next.page2Stat[`OCP_PS_OK] = !(s_next.burnUv || s_next.burnOv);
            s_next.page2Stat[`OCP_PS_UV] = !s_next.burnUv;
            s_next.page2Stat[`OCP_PS_OV] = !s_next.burnOv;
            s_next.page2Stat[`OCP_PS_LOADED] = 1'b1;
          end else begin
            s_next.page1Stat[`OCP_PS_OK] = !(s_next.burnUv || s_next.burnOv);
            s_next.page1Stat[`OCP_PS_UV] = !s_next.burnUv;
            s_next.page1Stat[`OCP_PS_OV] = !s_next.burnOv;
          end
        end
      end
      default: s_next.st = OCP_IDLE;
    endcase
    // registered so the busy pin never glitches on a state decode
    s_next.busy = s_next.st == OCP_STAB || s_next.st == OCP_BURN;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg <= '0;
      s_reg.st <= OCP_LOAD;
      s_reg.loadPend <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdData = s_reg.rdData;
  assign burnBusy = s_reg.busy;
  assign softResetPulse = s_reg.softRst;

  // checks
  a_trigger_needs_unlock: assert property (@(posedge clk) disable iff (!arst_n)
    (s_reg.st == OCP_IDLE && s_next.st == OCP_STAB) |-> s_reg.unlocked)
    else $error("burn started without unlock");
  a_hot_refuse: assert property (@(posedge clk) disable iff (!arst_n)
    (goValid && dieTooHot) |=> s_reg.st != OCP_STAB)
    else $error("burn started while hot");
  a_done_alone: assert property (@(posedge clk) disable iff (!arst_n)
    (s_reg.st == OCP_BURN && s_next.st == OCP_IDLE && !burnUnderVolt && !burnOverVolt && !s_reg.burnUv && !s_reg.burnOv)
    |=> s_reg.burnStat == 8'h01)
    else $error("done not alone");
  a_stab_no_try: assert property (@(posedge clk) disable iff (!arst_n)
    (s_reg.st == OCP_STAB && (burnUnderVolt || burnOverVolt))
    |=> $stable(s_reg.page1Stat[`OCP_PS_TRY]) && $stable(s_reg.page2Stat[`OCP_PS_TRY]))
    else $error("attempt set after failed stability");
  a_bad_page: assert property (@(posedge clk) disable iff (!arst_n)
    (goValid && !pageAvail) |=> s_reg.burnStat[`OCP_BS_PAGE] && s_reg.st == OCP_IDLE)
    else $error("bad page not flagged");
  a_key_void: assert property (@(posedge clk) disable iff (!arst_n)
    (rdStb && s_reg.key != KS_NONE) |=> s_reg.key == KS_NONE)
    else $error("read did not void key");
  a_unlock_flag: assert property (@(posedge clk) disable iff (!arst_n)
    (wrStb && s_reg.st == OCP_IDLE && s_reg.key == KS_2C && addr == `OCP_A_KEY2D && wrData == `OCP_K2D)
    |=> s_reg.unlocked && s_reg.burnStat[`OCP_BS_UNLOCK])
    else $error("unlock flag missing");
  a_uv_clear: assert property (@(posedge clk) disable iff (!arst_n)
    (s_reg.st == OCP_BURN && burnUnderVolt && s_reg.cnt == CW'(BURN_CYC - 1) && !s_reg.burnPage)
    |=> !s_reg.page1Stat[`OCP_PS_UV])
    else $error("uv-clear flag not cleared");

  // burn flow steps
  sequence s_stab_pass;
    s_reg.st == OCP_STAB && s_reg.cnt == CW'(STAB_CYC - 1) && !burnUnderVolt && !burnOverVolt;
  endsequence
  sequence s_burn_start;
    s_reg.st == OCP_BURN && s_reg.cnt == '0;
  endsequence
  sequence s_burn_last;
    s_reg.st == OCP_BURN && s_reg.cnt == CW'(BURN_CYC - 1);
  endsequence
  a_stab_to_burn: assert property (@(posedge clk) disable iff (!arst_n)
    s_stab_pass |=> s_burn_start)
    else $error("stability pass did not start burn");
  a_burn_finish: assert property (@(posedge clk) disable iff (!arst_n)
    s_burn_last |=> s_reg.st == OCP_IDLE && s_reg.burnStat[`OCP_BS_DONE])
    else $error("burn did not finish on time");
  a_page1_ok: assert property (@(posedge clk) disable iff (!arst_n)
    (s_reg.st == OCP_BURN && s_reg.cnt == CW'(BURN_CYC - 1) && !s_reg.burnPage && !s_reg.burnUv && !s_reg.burnOv
      && !burnUnderVolt && !burnOverVolt)
    |=> s_reg.page1Stat[`OCP_PS_OK] && s_reg.page1Stat[`OCP_PS_TRY] && s_reg.page1Stat[`OCP_PS_OV]
      && s_reg.page1Stat[`OCP_PS_UV])
    else $error("page one status wrong after burn");
  a_page2_loaded: assert property (@(posedge clk) disable iff (!arst_n)
    (s_reg.st == OCP_BURN && s_reg.cnt == CW'(BURN_CYC - 1) && s_reg.burnPage) |=> s_reg.page2Stat[`OCP_PS_LOADED])
    else $error("page two load flag missing");
  a_ov_clear: assert property (@(posedge clk) disable iff (!arst_n)
    (s_reg.st == OCP_BURN && s_reg.cnt == CW'(BURN_CYC - 1) && s_reg.burnPage && burnOverVolt)
    |=> !s_reg.page2Stat[`OCP_PS_OV])
    else $error("ov-clear flag not cleared");
  a_hot_flag: assert property (@(posedge clk) disable iff (!arst_n)
    (goValid && pageAvail && dieTooHot) |=> s_reg.burnStat[`OCP_BS_HOT] && s_reg.st == OCP_IDLE)
    else $error("hot refusal not flagged");
  a_stab_flag: assert property (@(posedge clk) disable iff (!arst_n)
    (s_reg.st == OCP_STAB && burnUnderVolt) |=> s_reg.burnStat[`OCP_BS_SUV] && s_reg.st == OCP_IDLE)
    else $error("stability uv not flagged");
  a_soft_reload: assert property (@(posedge clk) disable iff (!arst_n)
    (wrStb && s_reg.st == OCP_IDLE && addr == `OCP_A_CTRL1 && wrData[`OCP_CTRL1_SOFTRST])
    |=> s_reg.st == OCP_LOAD && softResetPulse)
    else $error("soft reset did not reload");
  a_load_source: assert property (@(posedge clk) disable iff (!arst_n)
    (s_reg.st == OCP_LOAD && !s_reg.loadPend && s_reg.loadIdx == AW'(2*BLOCKS-1) && s_reg.page1Stat[`OCP_PS_OK]
      && !s_reg.page2Stat[`OCP_PS_OK]) |=> s_reg.page1Stat[`OCP_PS_LOADED])
    else $error("load source not flagged");
  a_rd_idle: assert property (@(posedge clk) disable iff (!arst_n)
    !rdStb |=> rdData == `OCP_ZERO8)
    else $error("read data outside its cycle");
endmodule // ocp_programmer
`default_nettype wire

// >>> test/ocp_host_model.sv
// register bus master standing in for the host controller
`timescale 1ns/1ps
`default_nettype none
module ocp_host_model (
  input wire logic clk,
  output logic [7:0] addr,
  output logic [7:0] wrData,
  output logic wrStb,
  output logic rdStb,
  input wire logic [7:0] rdData
);
  initial begin
    addr = 8'h00;
    wrData = 8'h00;
    wrStb = 1'b0;
    rdStb = 1'b0;
  end
  // strobe left high on exit so key bytes go out back to back
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wrData <= d;
    wrStb <= 1'b1;
    rdStb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic idle();
    wrStb <= 1'b0;
    rdStb <= 1'b0;
    @(posedge clk);
  endtask
  // data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    addr <= a;
    rdStb <= 1'b1;
    wrStb <= 1'b0;
    @(posedge clk);
    rdStb <= 1'b0;
    @(negedge clk);
    d = rdData;
    @(posedge clk);
  endtask
endmodule // ocp_host_model
`default_nettype wire

// >>> test/tb_top.sv
// self-checking bench for the customer page programmer
`timescale 1ns/1ps
`default_nettype none
`include "ocp_consts.svh"
module tb_top;
  localparam int BURN = 50;
  localparam int STAB = 16;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] addr;
  logic [7:0] wrData;
  logic [7:0] rdData;
  logic wrStb;
  logic rdStb;
  logic burnUnderVolt = 1'b0;
  logic burnOverVolt = 1'b0;
  logic dieTooHot = 1'b0;
  logic burnBusy;
  logic softResetPulse;
  int errors = 0;
  int cmp_count = 0;
  int n;
  int c;
  logic [31:0] rng = 32'h0000005C;
  logic [7:0] rv;
  logic [7:0] keys [8] = '{`OCP_K1A, `OCP_K1B, `OCP_K1C, `OCP_K1D, `OCP_K2A, `OCP_K2B, `OCP_K2C, `OCP_K2D};

  // short burn so the run stays small
  ocp_programmer #(.BURN_CYC(BURN), .STAB_CYC(STAB)) i_ocp_programmer (.clk(clk), .arst_n(arst_n),
    .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .burnUnderVolt(burnUnderVolt),
    .burnOverVolt(burnOverVolt), .dieTooHot(dieTooHot), .burnBusy(burnBusy), .softResetPulse(softResetPulse));
  ocp_host_model i_ocp_host_model (.clk(clk), .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb),
    .rdData(rdData));

  initial begin
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic logic [7:0] okStat(input logic second);
    logic [7:0] s;
    s = 8'h00;
    s[`OCP_PS_OK] = 1'b1;
    s[`OCP_PS_LOADED] = second;
    s[`OCP_PS_TRY] = 1'b1;
    s[`OCP_PS_OV] = 1'b1;
    s[`OCP_PS_UV] = 1'b1;
    return s;
  endfunction
  task automatic complete_run();
    if (errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic ck(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    i_ocp_host_model.rd(a, rv);
    chk(rv & m, e, $sformatf("reg %h", a));
  endtask
  // bad from 1 to 7 spoils that step: a read slipped in or a wrong byte
  task automatic unlock(input int bad, input logic [7:0] junk);
    for (int i = 0; i < 8; i++) begin
      if (i == bad && junk[0]) i_ocp_host_model.rd(`OCP_A_BURN_STAT, rv);
      i_ocp_host_model.wr(`OCP_A_KEY1A + 8'(i), (i == bad && !junk[0]) ? keys[i] ^ {junk[7:1], 1'b1} : keys[i]);
    end
  endtask
  task automatic burn(input logic [7:0] v);
    i_ocp_host_model.wr(`OCP_A_BURN_CTRL, v);
    i_ocp_host_model.idle();
  endtask
  // bounded wait on the busy level; ends just after a rising edge
  task automatic waitBusy(input logic lvl, output int cyc);
    cyc = 0;
    do begin
      @(negedge clk);
      cyc++;
    end while (burnBusy !== lvl && cyc < 400);
    chk({7'h00, burnBusy}, {7'h00, lvl}, "busy level");
    @(posedge clk);
  endtask

  initial begin
    #400000;
    errors++;
    complete_run();
  end

  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (40) @(posedge clk);
    ck(`OCP_A_PAGE1_STAT, 8'h31, 8'h00);
    ck(`OCP_A_PAGE2_STAT, 8'h31, 8'h00);
    ck(8'h3F, 8'hFF, 8'h00);
    for (int k = 0; k < 6; k++) begin
      rng = xs(rng);
      unlock(int'(rng[2:0]) % 7 + 1, rng[15:8]);
      i_ocp_host_model.idle();
      ck(`OCP_A_BURN_STAT, 8'h02, 8'h00);
    end
    // hot die: trigger must be refused
    dieTooHot <= 1'b1;
    unlock(8, 8'h00);
    burn(`OCP_GO_PAGE1);
    repeat (30) @(posedge clk);
    chk({7'h00, burnBusy}, 8'h00, "hot busy");
    ck(`OCP_A_BURN_STAT, 8'h80, 8'h80);
    ck(`OCP_A_PAGE1_STAT, 8'h10, 8'h00);
    dieTooHot <= 1'b0;
    // supply sags in the stability test; page must stay available
    unlock(8, 8'h00);
    burn(`OCP_GO_PAGE1);
    waitBusy(1'b1, c);
    // sag lands a few cycles into the test, well before it would pass
    burnUnderVolt <= 1'b1;
    waitBusy(1'b0, c);
    burnUnderVolt <= 1'b0;
    ck(`OCP_A_BURN_STAT, 8'h10, 8'h10);
    ck(`OCP_A_PAGE1_STAT, 8'h10, 8'h00);
    // any other write between unlock and trigger relocks
    unlock(8, 8'h00);
    i_ocp_host_model.wr(`OCP_A_KEY1A, 8'h00);
    burn(`OCP_GO_PAGE1);
    repeat (5) @(posedge clk);
    chk({7'h00, burnBusy}, 8'h00, "relock");
    unlock(8, 8'h00);
    i_ocp_host_model.idle();
    ck(`OCP_A_BURN_STAT, 8'h02, 8'h02);
    burn(`OCP_GO_PAGE1);
    waitBusy(1'b1, c);
    waitBusy(1'b0, c);
    chk({7'h00, 1'(c >= STAB + BURN - 2 && c <= STAB + BURN + 1)}, 8'h01, "burn length");
    ck(`OCP_A_BURN_STAT, 8'hFF, 8'h01);
    ck(`OCP_A_PAGE1_STAT, 8'hFF, okStat(1'b0));
    // page one is spent now
    unlock(8, 8'h00);
    burn(`OCP_GO_PAGE1);
    repeat (5) @(posedge clk);
    chk({7'h00, burnBusy}, 8'h00, "bad page busy");
    ck(`OCP_A_BURN_STAT, 8'h40, 8'h40);
    // supply over limit in mid-burn of page two
    unlock(8, 8'h00);
    burn(`OCP_GO_PAGE2);
    waitBusy(1'b1, c);
    repeat (STAB + 5) @(posedge clk);
    burnOverVolt <= 1'b1;
    waitBusy(1'b0, c);
    burnOverVolt <= 1'b0;
    ck(`OCP_A_PAGE2_STAT, 8'h50, 8'h10);
    ck(`OCP_A_BURN_STAT, 8'h08, 8'h08);
    n = 0;
    i_ocp_host_model.wr(`OCP_A_CTRL1, 8'h01);
    fork
      i_ocp_host_model.idle();
      repeat (4) begin
        @(negedge clk);
        n += int'(softResetPulse);
      end
    join
    @(posedge clk);
    chk(8'(n), 8'h01, "soft reset pulse");
    repeat (40) @(posedge clk);
    ck(`OCP_A_PAGE1_STAT, 8'h03, 8'h03);
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
